// ---- design/rsq_defs.svh ----
// Register offsets, field positions, reset values and counts of the reset sequencer
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH

// Register byte offsets
`define RSQ_OFF_SWITCH_CONTROL_REG   8'h00
`define RSQ_OFF_SMBSTS  8'h04
`define RSQ_OFF_PHYLS   8'h08
`define RSQ_OFF_BOOT    8'h0c
`define RSQ_OFF_INTSTS  8'h10
`define RSQ_OFF_INTMSK  8'h14

// Field positions
`define RSQ_SWITCH_CONTROL_REG_HALT    0
`define RSQ_SWITCH_CONTROL_REG_UNLOCK  1
`define RSQ_SMB_DONE      0
`define RSQ_SMB_ERR       1
`define RSQ_SMB_CODE_LO   8
`define RSQ_INT_DONE      0
`define RSQ_INT_ERR       1
`define RSQ_INT_RUN       2
`define RSQ_INT_RETRAIN   3

// Error codes kept in the status register
`define RSQ_ERR_NONE  8'h00
`define RSQ_ERR_SMB   8'h01
`define RSQ_ERR_ADDR  8'h02

// Reset values and counts
`define RSQ_INT_RST      4'h0
`define RSQ_SYNC_CYC     2'h2
`define RSQ_EEP_ADDR_RST 16'h0000

`endif

// ---- design/rsq_pkg.sv ----
// Types shared by the reset sequencer
package rsq_pkg;

    typedef enum logic [2:0] {
        RSQ_S_CAPTURE = 3'b000,
        RSQ_S_UNLOCK  = 3'b001,
        RSQ_S_LDREQ   = 3'b010,
        RSQ_S_LDWAIT  = 3'b011,
        RSQ_S_HALT    = 3'b100,
        RSQ_S_RELOCK  = 3'b101,
        RSQ_S_RUN     = 3'b110
    } rsq_state_t;

    typedef enum logic [2:0] {
        RSQ_R_NONE   = 3'b000,
        RSQ_R_SWITCH_CONTROL_REG  = 3'b001,
        RSQ_R_SMBSTS = 3'b010,
        RSQ_R_PHYLS  = 3'b011,
        RSQ_R_BOOT   = 3'b100,
        RSQ_R_INTSTS = 3'b101,
        RSQ_R_INTMSK = 3'b110
    } rsq_sel_t;

    // One EEPROM record: last flag, target offset, data
    typedef struct packed {
        logic        last;
        logic [6:0]  rsv;
        logic [7:0]  offset;
        logic [15:0] data;
    } rsq_rec_t;

    // One incoming TLP as seen by the sequencer
    typedef struct packed {
        logic cfg_type0;
        logic cfg_other;
    } rsq_tlp_t;

endpackage

// ---- design/rsq_seq.sv ----
// Reset, EEPROM load and quasi-reset sequencer with APB registers
// Operation
// R1 - EEPROM modes load records into registers
// R2 - Config requests get retry status while loading
// R3 - Loaded retrain bit retrains that port
// R4 - Load error aborts, sets halt, logs error
// R5 - Completion sets done, normal unless halted
// R6 - Halt bit set puts ports quasi-reset
// R7 - Quasi-reset: type 0 config gets retry
// R8 - Quasi-reset: other TLPs dropped, credits returned
// R9 - Quasi-reset holds until halt bit cleared
// R10 - Host initializes then clears halt bit
// R11 - After release, unlock bit is cleared
// R12 - Then normal operation per captured mode
// R13 - EEPROM contents finish load within 200 ms
// R14 - Side effects fire at each record write
// R15 - Boot pins captured at reset release
// R16 - Unlock bit set early after defaults
// R17 - Load uses sequential EEPROM read transactions
`timescale 1ns/1ns
`default_nettype none
`include "rsq_defs.svh"

module rsq_seq #(
    parameter int NUM_PORTS = 16
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [3:0]            boot_switch_mode_code,
    input  wire logic                  boot_reset_halt,
    output logic                       eep_rd_req,
    output logic [15:0]                eep_rd_addr,
    input  wire logic                  eep_rd_ack,
    input  wire logic [31:0]           eep_rd_data,
    input  wire logic                  eep_rd_err,
    input  wire logic                  tlp_valid,
    input  wire rsq_pkg::rsq_tlp_t     tlp_in,
    output logic                       cfg_crs,
    output logic                       tlp_accept,
    output logic                       tlp_discard,
    output logic                       credit_return,
    output logic [NUM_PORTS-1:0]       port_retrain,
    output logic                       port_quasi_reset,
    output logic                       normal_op,
    output logic [3:0]                 switch_mode_code,
    output logic                       irq
);

    // Register select from a byte offset, used by APB and loader
    function automatic rsq_pkg::rsq_sel_t reg_sel(input logic [7:0] off);
        case (off)
            `RSQ_OFF_SWITCH_CONTROL_REG:  reg_sel = rsq_pkg::RSQ_R_SWITCH_CONTROL_REG;
            `RSQ_OFF_SMBSTS: reg_sel = rsq_pkg::RSQ_R_SMBSTS;
            `RSQ_OFF_PHYLS:  reg_sel = rsq_pkg::RSQ_R_PHYLS;
            `RSQ_OFF_BOOT:   reg_sel = rsq_pkg::RSQ_R_BOOT;
            `RSQ_OFF_INTSTS: reg_sel = rsq_pkg::RSQ_R_INTSTS;
            `RSQ_OFF_INTMSK: reg_sel = rsq_pkg::RSQ_R_INTMSK;
            default:         reg_sel = rsq_pkg::RSQ_R_NONE;
        endcase
    endfunction

    // Modes that include EEPROM initialization
    function automatic logic mode_has_eeprom(input logic [3:0] m);
        mode_has_eeprom = (m == 4'h1) || (m == 4'hd) || (m == 4'ha) || (m == 4'hb);
    endfunction

    rsq_pkg::rsq_state_t   state_reg, state_next;
    logic                  halt_s1_reg, halt_s2_reg;
    logic [1:0]            cap_cnt_reg, cap_cnt_next;
    logic [3:0]            mode_reg, mode_next;
    logic                  halt_reg, halt_next;
    logic                  unlock_reg, unlock_next;
    logic                  done_reg, done_next;
    logic                  err_reg, err_next;
    logic [7:0]            code_reg, code_next;
    logic [3:0]            ists_reg, ists_next;
    logic [3:0]            imsk_reg, imsk_next;
    logic [15:0]           eaddr_reg, eaddr_next;
    logic [NUM_PORTS-1:0]  rtr_reg, rtr_next;
    logic                  crs_reg, crs_next;
    logic                  acc_reg, acc_next;
    logic                  dis_reg, dis_next;
    logic                  cred_reg, cred_next;
    logic [31:0]           rdata_reg, rdata_next;
    logic [3:0]            msync_s1_reg, msync_s2_reg;

    rsq_pkg::rsq_rec_t     rec;
    rsq_pkg::rsq_sel_t     apb_sel, rec_sel;
    logic                  rec_take;
    logic                  apb_wr;
    logic                  apb_acc;

    assign rec      = eep_rd_data;
    assign rec_sel  = reg_sel(rec.offset);
    assign apb_sel  = reg_sel(paddr);
    assign rec_take = (state_reg == rsq_pkg::RSQ_S_LDWAIT) && eep_rd_ack;
    // Bus stalls only in the cycle a loaded record is taken
    assign pready   = !rec_take;
    assign apb_acc  = psel && penable && pready;
    assign apb_wr   = apb_acc && pwrite;
    assign pslverr  = apb_acc && (apb_sel == rsq_pkg::RSQ_R_NONE);

    // Two-flop synchronizers on the boot pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msync_s1_reg <= 4'h0;
            msync_s2_reg <= 4'h0;
            halt_s1_reg  <= 1'b0;
            halt_s2_reg  <= 1'b0;
        end else begin
            msync_s1_reg <= boot_switch_mode_code;
            msync_s2_reg <= msync_s1_reg;
            halt_s1_reg  <= boot_reset_halt;
            halt_s2_reg  <= halt_s1_reg;
        end
    end

    // Sequencer, registers and TLP answers: next values
    always_comb begin
        state_next   = state_reg;
        cap_cnt_next = cap_cnt_reg;
        mode_next    = mode_reg;
        halt_next    = halt_reg;
        unlock_next  = unlock_reg;
        done_next    = done_reg;
        err_next     = err_reg;
        code_next    = code_reg;
        ists_next    = ists_reg;
        imsk_next    = imsk_reg;
        eaddr_next   = eaddr_reg;
        rtr_next     = '0;
        crs_next     = 1'b0;
        acc_next     = 1'b0;
        dis_next     = 1'b0;
        cred_next    = 1'b0;

        // Software writes
        if (apb_wr) begin
            case (apb_sel)
                rsq_pkg::RSQ_R_SWITCH_CONTROL_REG: begin
                    halt_next   = pwdata[`RSQ_SWITCH_CONTROL_REG_HALT];   // see R9
                    unlock_next = pwdata[`RSQ_SWITCH_CONTROL_REG_UNLOCK];
                end
                rsq_pkg::RSQ_R_PHYLS:  rtr_next  = pwdata[NUM_PORTS-1:0];
                rsq_pkg::RSQ_R_INTSTS: ists_next = ists_reg & ~pwdata[3:0];
                rsq_pkg::RSQ_R_INTMSK: imsk_next = pwdata[3:0];
                default: ;
            endcase
        end

        case (state_reg)
            // Wait for synchronizers, then latch the boot vector
            rsq_pkg::RSQ_S_CAPTURE: begin
                if (cap_cnt_reg == `RSQ_SYNC_CYC) begin
                    mode_next  = msync_s2_reg;          // see R15
                    halt_next  = halt_s2_reg;           // see R15
                    state_next = rsq_pkg::RSQ_S_UNLOCK;
                end else begin
                    cap_cnt_next = cap_cnt_reg + 2'h1;
                end
            end
            rsq_pkg::RSQ_S_UNLOCK: begin
                unlock_next = 1'b1;                     // see R16
                eaddr_next  = `RSQ_EEP_ADDR_RST;
                if (mode_has_eeprom(mode_reg)) begin    // see R1
                    state_next = rsq_pkg::RSQ_S_LDREQ;
                end else if (halt_next) begin
                    state_next = rsq_pkg::RSQ_S_HALT;
                end else begin
                    state_next = rsq_pkg::RSQ_S_RELOCK;
                end
            end
            rsq_pkg::RSQ_S_LDREQ: begin
                state_next = rsq_pkg::RSQ_S_LDWAIT;     // see R17
            end
            rsq_pkg::RSQ_S_LDWAIT: begin
                if (rec_take) begin
                    if (eep_rd_err || rec_sel == rsq_pkg::RSQ_R_NONE) begin
                        halt_next  = 1'b1;              // see R4
                        err_next   = 1'b1;
                        code_next  = eep_rd_err ? `RSQ_ERR_SMB : `RSQ_ERR_ADDR;
                        done_next  = 1'b1;
                        ists_next[`RSQ_INT_ERR] = 1'b1;
                        state_next = rsq_pkg::RSQ_S_HALT;  // see R6
                    end else begin
                        // Record write acts at once, side effects included
                        case (rec_sel)
                            rsq_pkg::RSQ_R_SWITCH_CONTROL_REG: begin
                                halt_next   = rec.data[`RSQ_SWITCH_CONTROL_REG_HALT];
                                unlock_next = rec.data[`RSQ_SWITCH_CONTROL_REG_UNLOCK];
                            end
                            rsq_pkg::RSQ_R_PHYLS: begin
                                rtr_next = rec.data[NUM_PORTS-1:0];  // see R3, R14
                            end
                            rsq_pkg::RSQ_R_INTMSK: imsk_next = rec.data[3:0];
                            default: ;
                        endcase
                        eaddr_next = eaddr_reg + 16'h0001;  // see R17
                        if (rec.last) begin
                            done_next  = 1'b1;          // see R5
                            ists_next[`RSQ_INT_DONE] = 1'b1;
                            state_next = halt_next ? rsq_pkg::RSQ_S_HALT
                                                   : rsq_pkg::RSQ_S_RELOCK;
                        end else begin
                            state_next = rsq_pkg::RSQ_S_LDREQ;
                        end
                    end
                end
            end
            rsq_pkg::RSQ_S_HALT: begin
                if (!halt_reg) begin
                    state_next = rsq_pkg::RSQ_S_RELOCK; // see R9, R10
                end
            end
            rsq_pkg::RSQ_S_RELOCK: begin
                unlock_next = 1'b0;                     // see R11
                ists_next[`RSQ_INT_RUN] = 1'b1;
                state_next  = rsq_pkg::RSQ_S_RUN;       // see R12
            end
            rsq_pkg::RSQ_S_RUN: ;
            default: state_next = rsq_pkg::RSQ_S_CAPTURE;
        endcase

        if (rtr_next != '0) begin
            ists_next[`RSQ_INT_RETRAIN] = 1'b1;
        end

        // Answer each TLP according to the phase
        if (tlp_valid) begin
            if (state_reg == rsq_pkg::RSQ_S_RUN) begin
                acc_next = 1'b1;
            end else if (state_reg == rsq_pkg::RSQ_S_HALT) begin
                crs_next  = tlp_in.cfg_type0;           // see R7
                dis_next  = !tlp_in.cfg_type0;          // see R8
                cred_next = 1'b1;                       // see R8
            end else begin
                crs_next  = tlp_in.cfg_type0 || tlp_in.cfg_other;  // see R2
                dis_next  = !(tlp_in.cfg_type0 || tlp_in.cfg_other);
                cred_next = 1'b1;
            end
        end
    end

    // Sequencer, registers and TLP answers: storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= rsq_pkg::RSQ_S_CAPTURE;
            cap_cnt_reg <= 2'h0;
            mode_reg    <= 4'h0;
            halt_reg    <= 1'b0;
            unlock_reg  <= 1'b0;
            done_reg    <= 1'b0;
            err_reg     <= 1'b0;
            code_reg    <= `RSQ_ERR_NONE;
            ists_reg    <= `RSQ_INT_RST;
            imsk_reg    <= `RSQ_INT_RST;
            eaddr_reg   <= `RSQ_EEP_ADDR_RST;
            rtr_reg     <= '0;
            crs_reg     <= 1'b0;
            acc_reg     <= 1'b0;
            dis_reg     <= 1'b0;
            cred_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cap_cnt_reg <= cap_cnt_next;
            mode_reg    <= mode_next;
            halt_reg    <= halt_next;
            unlock_reg  <= unlock_next;
            done_reg    <= done_next;
            err_reg     <= err_next;
            code_reg    <= code_next;
            ists_reg    <= ists_next;
            imsk_reg    <= imsk_next;
            eaddr_reg   <= eaddr_next;
            rtr_reg     <= rtr_next;
            crs_reg     <= crs_next;
            acc_reg     <= acc_next;
            dis_reg     <= dis_next;
            cred_reg    <= cred_next;
        end
    end

    // Read data latched in the setup phase
    always_comb begin
        rdata_next = rdata_reg;
        if (psel && !penable) begin
            rdata_next = 32'h0000_0000;
            case (apb_sel)
                rsq_pkg::RSQ_R_SWITCH_CONTROL_REG: begin
                    rdata_next[`RSQ_SWITCH_CONTROL_REG_HALT]   = halt_reg;
                    rdata_next[`RSQ_SWITCH_CONTROL_REG_UNLOCK] = unlock_reg;
                end
                rsq_pkg::RSQ_R_SMBSTS: begin
                    rdata_next[`RSQ_SMB_DONE] = done_reg;
                    rdata_next[`RSQ_SMB_ERR]  = err_reg;
                    rdata_next[`RSQ_SMB_CODE_LO +: 8] = code_reg;
                end
                rsq_pkg::RSQ_R_BOOT: begin
                    rdata_next[3:0] = mode_reg;
                    rdata_next[4]   = halt_s2_reg;
                end
                rsq_pkg::RSQ_R_INTSTS: rdata_next[3:0] = ists_reg;
                rsq_pkg::RSQ_R_INTMSK: rdata_next[3:0] = imsk_reg;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Outputs
    assign prdata           = rdata_reg;
    assign eep_rd_req       = (state_reg == rsq_pkg::RSQ_S_LDWAIT);
    assign eep_rd_addr      = eaddr_reg;
    assign cfg_crs          = crs_reg;
    assign tlp_accept       = acc_reg;
    assign tlp_discard      = dis_reg;
    assign credit_return    = cred_reg;
    assign port_retrain     = rtr_reg;
    assign port_quasi_reset = (state_reg == rsq_pkg::RSQ_S_HALT);   // see R6
    assign normal_op        = (state_reg == rsq_pkg::RSQ_S_RUN);
    assign switch_mode_code = mode_reg;
    assign irq              = |(ists_reg & imsk_reg);

endmodule

`default_nettype wire

// ---- dv/rsq_eep_model.sv ----
// Behavioural EEPROM on the master SMBus, serving fixed records
`timescale 1ns/1ns
`default_nettype none
module rsq_eep_model (
    input wire logic   pclk,
    input wire logic   presetn,
    input wire logic   eep_rd_req,
    input wire logic [15:0] eep_rd_addr,
    input wire logic [3:0]  wait_cyc,
    input wire logic [15:0] err_at,
    output var logic        eep_rd_ack,
    output var logic [31:0] eep_rd_data,
    output var logic        eep_rd_err
);
    logic [3:0] cnt;
    // Record 0 retrains port 2, record 1 loads the mask and ends
    function automatic logic [31:0] rec(input logic [15:0] a);
        return (a == 16'h0000) ? 32'h0008_0004 : 32'h8014_000f;
    endfunction
    // One answer per read after a wait; data line inverted when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            eep_rd_ack <= 1'b0;
            eep_rd_data <= 32'h0;
            eep_rd_err <= 1'b0;
        end else if (eep_rd_req && !eep_rd_ack && cnt >= wait_cyc) begin
            cnt <= 4'h0;
            eep_rd_ack <= 1'b1;
            eep_rd_data <= rec(eep_rd_addr);
            eep_rd_err <= (eep_rd_addr == err_at);
        end else begin
            cnt <= (eep_rd_req && !eep_rd_ack) ? cnt + 4'h1 : 4'h0;
            eep_rd_ack <= 1'b0;
            eep_rd_data <= ~eep_rd_data;
            eep_rd_err <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/rsq_seq_props.sv ----
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ns
`default_nettype none
module rsq_seq_props #(
    parameter int NUM_PORTS = 16
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [3:0]           boot_switch_mode_code,
    input wire logic                 boot_reset_halt,
    input wire logic                 eep_rd_req,
    input wire logic [15:0]          eep_rd_addr,
    input wire logic                 eep_rd_ack,
    input wire logic [31:0]          eep_rd_data,
    input wire logic                 eep_rd_err,
    input wire logic                 tlp_valid,
    input wire rsq_pkg::rsq_tlp_t    tlp_in,
    input wire logic                 cfg_crs,
    input wire logic                 tlp_accept,
    input wire logic                 tlp_discard,
    input wire logic                 credit_return,
    input wire logic [NUM_PORTS-1:0] port_retrain,
    input wire logic                 port_quasi_reset,
    input wire logic                 normal_op,
    input wire logic [3:0]           switch_mode_code,
    input wire logic                 irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic switch_control_reg_clr;
    // Software write that clears the halt bit
    assign switch_control_reg_clr = psel && penable && pready && pwrite && paddr == 8'h00 && !pwdata[0];
    sequence s_rec_hit;
        eep_rd_req && eep_rd_ack && !eep_rd_err && eep_rd_data[23:16] == 8'h08;
    endsequence
    sequence s_release;
        port_quasi_reset && switch_control_reg_clr;
    endsequence
    a_retrain_rec: assert property (s_rec_hit |=>
        port_retrain == $past(eep_rd_data[NUM_PORTS-1:0])) else $error("retrain mismatch");
    a_load_crs: assert property (eep_rd_req && tlp_valid && tlp_in != 2'b00 |=>
        cfg_crs && credit_return && !tlp_accept) else $error("no retry while loading");
    a_quasi_type0: assert property (port_quasi_reset && tlp_valid && tlp_in.cfg_type0 |=>
        cfg_crs && credit_return) else $error("no retry in quasi-reset");
    a_quasi_drop: assert property (port_quasi_reset && tlp_valid && !tlp_in.cfg_type0 |=>
        tlp_discard && credit_return && !cfg_crs) else $error("tlp not dropped");
    a_run_accept: assert property (normal_op && tlp_valid |=>
        tlp_accept && !tlp_discard && !cfg_crs) else $error("tlp not accepted");
    a_halt_hold: assert property ((port_quasi_reset && !switch_control_reg_clr) [*2] |=>
        port_quasi_reset) else $error("quasi-reset left early");
    a_halt_exit: assert property (s_release |-> ##[1:4] normal_op)
        else $error("no run after release");
    a_err_halt: assert property (eep_rd_req && eep_rd_ack && eep_rd_err |->
        ##[1:4] port_quasi_reset && !normal_op) else $error("error did not halt");
    a_load_idle: assert property (eep_rd_req |-> !normal_op && !port_quasi_reset)
        else $error("run during load");
    a_req_hold: assert property (eep_rd_req && !eep_rd_ack |=>
        eep_rd_req && $stable(eep_rd_addr)) else $error("read request dropped");
endmodule
bind rsq_seq rsq_seq_props #(.NUM_PORTS(NUM_PORTS)) u_props (.*);
`default_nettype wire

// ---- dv/tb_rsq_seq.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_rsq_seq;
    logic        pclk, presetn, psel, penable, pwrite, tlp_valid, boot_reset_halt;
    logic        pready, pslverr, eep_rd_req, eep_rd_ack, eep_rd_err, cfg_crs, tlp_accept;
    logic        tlp_discard, credit_return, port_quasi_reset, normal_op, irq, slv_err, retr_run;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, eep_rd_data, rd;
    logic [15:0] eep_rd_addr, port_retrain, err_at, retr_val;
    logic [3:0]  boot_switch_mode_code, switch_mode_code, wait_cyc;
    rsq_pkg::rsq_tlp_t tlp_in;
    int          error_cnt, total_checks;
    wire logic [2:0] flags = {port_quasi_reset, normal_op, eep_rd_req};

    rsq_seq #(.NUM_PORTS(16)) u_dut (.*);
    rsq_eep_model u_eep (.*);

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Remembers the last retrain pulse and whether run had begun
    always @(posedge pclk) begin
        if (!presetn) begin
            retr_val <= 16'h0;
            retr_run <= 1'b0;
        end else if (port_retrain != 16'h0) begin
            retr_val <= port_retrain;
            retr_run <= normal_op;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic [3:0] mode, input logic halt);
        @(posedge pclk);
        presetn <= 1'b0;
        boot_switch_mode_code <= mode;
        boot_reset_halt <= halt;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic wait_for(input int i);
        int n;
        n = 0;
        while (flags[i] !== 1'b1 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, flags[i]}, 32'h1);
    endtask
    // APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        while (pready !== 1'b1) begin
            @(posedge pclk);
            #1;
        end
        @(posedge pclk);
        rd = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One TLP; reply pulses masked by m must equal e
    task automatic tlp(input logic [1:0] kind, input logic [3:0] m, input logic [3:0] e);
        @(posedge pclk);
        tlp_valid <= 1'b1;
        tlp_in <= rsq_pkg::rsq_tlp_t'(kind);
        @(posedge pclk);
        tlp_valid <= 1'b0;
        #1;
        chk({28'h0, {cfg_crs, tlp_accept, tlp_discard, credit_return} & m}, {28'h0, e});
    endtask

    task automatic test_load;
        wait_cyc <= 4'hf;
        err_at <= 16'hffff;
        do_reset(4'h1, 1'b0);
        wait_for(0);
        tlp(2'b10, 4'hf, 4'b1001);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_0002);
        wait_for(1);
        chk({16'h0, retr_val}, 32'h0000_0004);
        chk({31'h0, retr_run}, 32'h0);
        chk({28'h0, switch_mode_code}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_000d);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h10, 32'h0000_000f);
        #1;
        chk({31'h0, irq}, 32'h0);
        tlp(2'b00, 4'h4, 4'h4);
        $display("test_load done at %0t", $time);
    endtask
    task automatic test_err;
        wait_cyc <= 4'h0;
        err_at <= 16'h0001;
        do_reset(4'hd, 1'b0);
        wait_for(2);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_0103);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_0003);
        tlp(2'b10, 4'hf, 4'b1001);
        tlp(2'b01, 4'hf, 4'b0011);
        tlp(2'b00, 4'hf, 4'b0011);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, slv_err}, 32'h1);
        chk({31'h0, port_quasi_reset}, 32'h1);
        apb(1'b1, 8'h00, 32'h0000_0002);
        wait_for(1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        $display("test_err done at %0t", $time);
    endtask
    task automatic test_pin;
        err_at <= 16'hffff;
        do_reset(4'h0, 1'b1);
        wait_for(2);
        chk({31'h0, eep_rd_req}, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0000_0010);
        apb(1'b1, 8'h00, 32'h0);
        wait_for(1);
        chk({28'h0, switch_mode_code}, 32'h0);
        $display("test_pin done at %0t", $time);
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, tlp_valid, boot_reset_halt} = 6'h0;
        {paddr, pwdata, tlp_in, boot_switch_mode_code} = 46'h0;
        {err_at, wait_cyc} = 20'h0;
        error_cnt = 0;
        total_checks = 0;
        test_load();
        test_err();
        test_pin();
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
